// File: src/pmbus_status_pkg.sv
package pmbus_status_pkg;

   localparam int NUM_CH = 8;
   localparam int PAGE_W = 3;

   // Command codes seen on the read port
   localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7A;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7D;
   localparam logic [7:0] CMD_STATUS_CML   = 8'h7E;
   localparam logic [7:0] CMD_STATUS_MFR   = 8'h80;
   localparam logic [7:0] CMD_READ_VIN     = 8'h88;
   localparam logic [7:0] CMD_READ_VOUT    = 8'h8B;
   localparam logic [7:0] CMD_READ_TEMP    = 8'h8D;
   localparam logic [7:0] CMD_REVISION     = 8'h98;

   // Output voltage status
   localparam int VO_OV_FAULT = 7;
   localparam int VO_OV_WARN  = 6;
   localparam int VO_UV_WARN  = 5;
   localparam int VO_UV_FAULT = 4;
   localparam int VO_MAX_WARN = 3;
   localparam int VO_TON_MAX  = 2;

   // Input voltage status
   localparam int IN_OV_FAULT = 7;
   localparam int IN_OV_WARN  = 6;
   localparam int IN_UV_WARN  = 5;
   localparam int IN_UV_FAULT = 4;
   localparam int IN_OFF      = 3;

   // Temperature status
   localparam int TP_OT_FAULT = 7;
   localparam int TP_OT_WARN  = 6;
   localparam int TP_UT_WARN  = 5;
   localparam int TP_UT_FAULT = 4;

   // Communication, memory and logic status
   localparam int CML_CMD  = 7;
   localparam int CML_DATA = 6;
   localparam int CML_PEC  = 5;
   localparam int CML_MEM  = 4;
   localparam int CML_BUS  = 1;

   // Vendor status
   localparam int MF_DISCHARGE = 7;
   localparam int MF_FAULT1    = 6;
   localparam int MF_FAULT0    = 5;
   localparam int MF_SERVO     = 4;
   localparam int MF_DAC_CONN  = 3;
   localparam int MF_DAC_SAT   = 2;
   localparam int MF_VINEN     = 1;
   localparam int MF_WATCHDOG  = 0;
   localparam logic [7:0] MF_ALERT_MASK = 8'hE1;

   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [15:0] WORD_RST   = 16'h0000;
   localparam logic [2:0]  SYNC_RST   = 3'h7;
   // Arbitrary neutral value
   localparam logic [7:0]  REVISION_DEFAULT = 8'h22;

endpackage

// File: src/pmbus_status_telemetry_regs.sv
`timescale 1ns/1ps
module pmbus_status_telemetry_regs
   import pmbus_status_pkg::*;
#(
   parameter logic [7:0] REVISION_CODE = REVISION_DEFAULT
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [NUM_CH-1:0] vout_ov_fault,
   input  wire logic [NUM_CH-1:0] vout_ov_warn,
   input  wire logic [NUM_CH-1:0] vout_uv_warn,
   input  wire logic [NUM_CH-1:0] vout_uv_fault,
   input  wire logic [NUM_CH-1:0] vout_ton_max_fault,
   input  wire logic              vout_cmd_req,
   input  wire logic [15:0]       vout_cmd_value,
   input  wire logic [15:0]       vout_max_limit,
   input  wire logic              vin_ov_fault,
   input  wire logic              vin_ov_warn,
   input  wire logic              vin_uv_warn,
   input  wire logic              vin_uv_fault,
   input  wire logic              vin_insufficient,
   input  wire logic              temp_ot_fault,
   input  wire logic              temp_ot_warn,
   input  wire logic              temp_ut_warn,
   input  wire logic              temp_ut_fault,
   input  wire logic              bad_command,
   input  wire logic              bad_data,
   input  wire logic              extra_byte,
   input  wire logic              extra_byte_pec_match,
   input  wire logic              nvm_fault,
   input  wire logic              malformed_txn,
   input  wire logic [NUM_CH-1:0] discharge_fault,
   input  wire logic [NUM_CH-1:0] turn_on_try,
   input  wire logic [NUM_CH-1:0] fb1_shutdown,
   input  wire logic [NUM_CH-1:0] fb0_shutdown,
   input  wire logic [NUM_CH-1:0] chan_on_cmd,
   input  wire logic [NUM_CH-1:0] servo_reached,
   input  wire logic [NUM_CH-1:0] dac_connected,
   input  wire logic [NUM_CH-1:0] dac_saturated,
   input  wire logic              vinen_faulted_off,
   input  wire logic              watchdog_fault,
   input  wire logic              clear_faults,
   input  wire logic              fault_bus_in_1_n,
   input  wire logic              fault_bus_in_0_n,
   input  wire logic              adc_vin_valid,
   input  wire logic [15:0]       adc_vin_word,
   input  wire logic              adc_vout_valid,
   input  wire logic [PAGE_W-1:0] adc_vout_ch,
   input  wire logic [15:0]       adc_vout_word,
   input  wire logic              adc_temp_valid,
   input  wire logic [15:0]       adc_temp_word,
   input  wire logic [NUM_CH-1:0] adc_hires,
   input  wire logic [PAGE_W-1:0] sel_page,
   input  wire logic              rd_req,
   input  wire logic [7:0]        rd_cmd,
   output logic                   rd_valid,
   output logic [15:0]            rd_data,
   output logic                   rd_l11,
   output logic                   rd_unsupported,
   output logic                   alert_out_n
);

   typedef struct packed {
      logic [2:0]              fb1_sync;
      logic [2:0]              fb0_sync;
      logic                    fb1_lvl;
      logic                    fb0_lvl;
      logic [NUM_CH-1:0][7:0]  vout;
      logic [7:0]              vin;
      logic [7:0]              temp;
      logic [7:0]              cml;
      logic [NUM_CH-1:0][7:0]  vend;
      logic                    watchdog;
      logic [15:0]             vin_word;
      logic [NUM_CH-1:0][15:0] vout_word;
      logic [15:0]             temp_word;
      logic [15:0]             rd_data;
      logic                    rd_valid;
      logic                    rd_l11;
      logic                    rd_unsupported;
      logic                    alert_n;
   } state_t;

   localparam state_t ST_RST = '{fb1_sync: SYNC_RST, fb0_sync: SYNC_RST,
                                 fb1_lvl: 1'b1, fb0_lvl: 1'b1,
                                 alert_n: 1'b1, default: '0};

   state_t st;
   state_t next_st;

   // Pin low at a turn-on attempt, or a shutdown caused by the pin
   function automatic logic fb_hit(input logic try_on,
                                   input logic pin_lvl,
                                   input logic shut);
      fb_hit = (try_on & ~pin_lvl) | shut;
   endfunction

   always_comb begin
      logic [7:0] vbyte;
      logic       any_alert;
      vbyte     = STATUS_RST;
      any_alert = 1'b0;
      next_st   = st;

      // Pin filter: a change counts once stages two and three agree
      next_st.fb1_sync = {st.fb1_sync[1:0], fault_bus_in_1_n};
      next_st.fb0_sync = {st.fb0_sync[1:0], fault_bus_in_0_n};
      if (st.fb1_sync[1] == st.fb1_sync[2]) begin
         next_st.fb1_lvl = st.fb1_sync[2];
      end
      if (st.fb0_sync[1] == st.fb0_sync[2]) begin
         next_st.fb0_lvl = st.fb0_sync[2];
      end

      // Clear first so that a same-cycle event survives
      if (clear_faults) begin
         next_st.vout     = '0;
         next_st.vin      = STATUS_RST;
         next_st.temp     = STATUS_RST;
         next_st.cml      = STATUS_RST;
         next_st.vend     = '0;
         next_st.watchdog = 1'b0;
      end

      for (int i = 0; i < NUM_CH; i++) begin
         if (chan_on_cmd[i]) begin
            next_st.vend[i] = STATUS_RST;
         end
         if (vout_ov_fault[i]) next_st.vout[i][VO_OV_FAULT] = 1'b1;
         if (vout_ov_warn[i])  next_st.vout[i][VO_OV_WARN]  = 1'b1;
         if (vout_uv_warn[i])  next_st.vout[i][VO_UV_WARN]  = 1'b1;
         if (vout_uv_fault[i]) next_st.vout[i][VO_UV_FAULT] = 1'b1;
         if (vout_ton_max_fault[i]) begin
            next_st.vout[i][VO_TON_MAX] = 1'b1;
         end
         // Same exponent assumed, so the mantissas compare directly
         if (vout_cmd_req && sel_page == PAGE_W'(i)
             && vout_cmd_value > vout_max_limit) begin
            next_st.vout[i][VO_MAX_WARN] = 1'b1;
         end
         if (discharge_fault[i]) begin
            next_st.vend[i][MF_DISCHARGE] = 1'b1;
         end
         if (fb_hit(turn_on_try[i], st.fb1_lvl, fb1_shutdown[i])) begin
            next_st.vend[i][MF_FAULT1] = 1'b1;
         end
         if (fb_hit(turn_on_try[i], st.fb0_lvl, fb0_shutdown[i])) begin
            next_st.vend[i][MF_FAULT0] = 1'b1;
         end
         if (dac_saturated[i]) begin
            next_st.vend[i][MF_DAC_SAT] = 1'b1;
         end
         if (adc_vout_valid && adc_vout_ch == PAGE_W'(i)) begin
            next_st.vout_word[i] = adc_vout_word;
         end
         any_alert = any_alert | (|(next_st.vend[i] & MF_ALERT_MASK));
      end

      if (vin_ov_fault)   next_st.vin[IN_OV_FAULT] = 1'b1;
      if (vin_ov_warn)    next_st.vin[IN_OV_WARN]  = 1'b1;
      if (vin_uv_warn)    next_st.vin[IN_UV_WARN]  = 1'b1;
      if (vin_uv_fault)   next_st.vin[IN_UV_FAULT] = 1'b1;
      if (temp_ot_fault)  next_st.temp[TP_OT_FAULT] = 1'b1;
      if (temp_ot_warn)   next_st.temp[TP_OT_WARN]  = 1'b1;
      if (temp_ut_warn)   next_st.temp[TP_UT_WARN]  = 1'b1;
      if (temp_ut_fault)  next_st.temp[TP_UT_FAULT] = 1'b1;
      if (bad_command)    next_st.cml[CML_CMD]  = 1'b1;
      if (bad_data)       next_st.cml[CML_DATA] = 1'b1;
      if (extra_byte && !extra_byte_pec_match) begin
         next_st.cml[CML_PEC] = 1'b1;
      end
      if (nvm_fault)      next_st.cml[CML_MEM] = 1'b1;
      if (malformed_txn)  next_st.cml[CML_BUS] = 1'b1;
      if (watchdog_fault) next_st.watchdog = 1'b1;
      if (adc_vin_valid)  next_st.vin_word  = adc_vin_word;
      if (adc_temp_valid) next_st.temp_word = adc_temp_word;

      // Every held fault or warning asserts the alert line, except the vendor DAC saturation bit, which MF_ALERT_MASK leaves out
      any_alert = any_alert | next_st.watchdog | (|next_st.vout)
                  | (|next_st.vin) | (|next_st.temp) | (|next_st.cml);
      next_st.alert_n = ~any_alert;

      // Reads only sample; no flag is touched here
      next_st.rd_valid       = rd_req;
      next_st.rd_data        = WORD_RST;
      next_st.rd_l11         = 1'b0;
      next_st.rd_unsupported = 1'b0;
      vbyte = st.vend[sel_page];
      vbyte[MF_SERVO]    = servo_reached[sel_page];
      vbyte[MF_DAC_CONN] = dac_connected[sel_page];
      vbyte[MF_VINEN]    = vinen_faulted_off;
      vbyte[MF_WATCHDOG] = st.watchdog;
      if (rd_req) begin
         case (rd_cmd)
            CMD_STATUS_VOUT: begin
               next_st.rd_data[7:0] = st.vout[sel_page];
            end
            CMD_STATUS_INPUT: begin
               next_st.rd_data[7:0]    = st.vin;
               next_st.rd_data[IN_OFF] = vin_insufficient;
            end
            CMD_STATUS_TEMP: begin
               next_st.rd_data[7:0] = st.temp;
            end
            CMD_STATUS_CML: begin
               next_st.rd_data[7:0] = st.cml;
            end
            CMD_STATUS_MFR: begin
               next_st.rd_data[7:0] = vbyte;
            end
            CMD_READ_VIN: begin
               next_st.rd_data = st.vin_word;
               next_st.rd_l11  = 1'b1;
            end
            CMD_READ_VOUT: begin
               next_st.rd_data = st.vout_word[sel_page];
               next_st.rd_l11  = sel_page[0] & adc_hires[sel_page];
            end
            CMD_READ_TEMP: begin
               next_st.rd_data = st.temp_word;
               next_st.rd_l11  = 1'b1;
            end
            CMD_REVISION: begin
               next_st.rd_data[7:0] = REVISION_CODE;
            end
            default: begin
               next_st.rd_unsupported = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign rd_valid       = st.rd_valid;
   assign rd_data        = st.rd_data;
   assign rd_l11         = st.rd_l11;
   assign rd_unsupported = st.rd_unsupported;
   assign alert_out_n    = st.alert_n;

   // Checks
   logic any_event;
   assign any_event = (|vout_ov_fault) | (|vout_ov_warn) | (|vout_uv_warn)
                      | (|vout_uv_fault) | (|vout_ton_max_fault)
                      | vout_cmd_req | vin_ov_fault | vin_ov_warn
                      | vin_uv_warn | vin_uv_fault | temp_ot_fault
                      | temp_ot_warn | temp_ut_warn | temp_ut_fault
                      | bad_command | bad_data | extra_byte | nvm_fault
                      | malformed_txn | (|discharge_fault) | (|turn_on_try)
                      | (|fb1_shutdown) | (|fb0_shutdown) | watchdog_fault;

   sequence read_of(logic [7:0] code);
      rd_req && rd_cmd == code;
   endsequence

   sequence quiet_clear;
      clear_faults && !any_event;
   endsequence

   vout_ov_latch_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      vout_ov_fault[0] || (st.vout[0][VO_OV_FAULT] && !clear_faults)
      |=> st.vout[0][VO_OV_FAULT])
      else $error("output overvoltage flag not held");

   max_warn_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      vout_cmd_req && vout_cmd_value > vout_max_limit
      |=> st.vout[$past(sel_page)][VO_MAX_WARN])
      else $error("voltage limit warning not set");

   vout_low_zero_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      read_of(CMD_STATUS_VOUT) |=> rd_valid && rd_data[1:0] == 2'h0)
      else $error("unsupported output status bits nonzero");

   temp_nibble_zero_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      read_of(CMD_STATUS_TEMP) |=> rd_data[3:0] == 4'h0)
      else $error("temperature low nibble nonzero");

   pec_fault_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      extra_byte && !extra_byte_pec_match ##1 !clear_faults
      ##1 read_of(CMD_STATUS_CML)
      |=> rd_data[CML_PEC])
      else $error("extra byte without PEC not flagged");

   cml_zero_bits_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      read_of(CMD_STATUS_CML) |=> rd_data[3:2] == 2'h0 && !rd_data[0])
      else $error("unsupported communication bits nonzero");

   watchdog_alert_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      watchdog_fault |=> !alert_out_n)
      else $error("alert not asserted on watchdog fault");

   chan_on_clear_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      chan_on_cmd[0] && !discharge_fault[0] && !turn_on_try[0]
      && !fb1_shutdown[0] && !fb0_shutdown[0] && !dac_saturated[0]
      |=> st.vend[0] == STATUS_RST)
      else $error("sticky vendor bits survive channel on");

   clear_release_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      quiet_clear |=> alert_out_n ##0 st.watchdog == 1'b0)
      else $error("clear faults did not release alert");

   revision_read_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      read_of(CMD_REVISION) |=> rd_valid ##0 rd_data == {8'h00, REVISION_CODE})
      else $error("revision byte wrong");

   read_keeps_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_req && !clear_faults && !any_event && !(|chan_on_cmd)
      && !(|dac_saturated) |=> $stable(st.cml) && $stable(st.vout))
      else $error("read disturbed status flags");

endmodule

// File: dv/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model
   import pmbus_status_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rd_valid,
   input  wire logic [15:0]       rd_data,
   input  wire logic              rd_l11,
   input  wire logic              rd_unsupported,
   output logic                   rd_req,
   output logic [7:0]             rd_cmd,
   output logic [PAGE_W-1:0]      sel_page
);
   initial begin
      rd_req = 1'h0;
      rd_cmd = 8'h00;
      sel_page = '0;
   end

   task automatic set_page(input logic [PAGE_W-1:0] p);
      sel_page = p;
   endtask

   // Request pulse at a falling edge, answer taken when valid shows
   task automatic read(input logic [7:0] cmd, input logic [PAGE_W-1:0] p,
                       output logic [15:0] d, output logic l,
                       output logic u, output bit ok);
      int n;
      ok = 1'b0;
      d = 16'h0000;
      l = 1'h0;
      u = 1'h0;
      @(negedge sys_clk);
      rd_req = 1'h1;
      rd_cmd = cmd;
      sel_page = p;
      @(negedge sys_clk);
      rd_req = 1'h0;
      // Idle code lines show junk so a stale code is never reused
      rd_cmd = ~cmd;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rd_valid === 1'h1) begin
            ok = 1'b1;
            d = rd_data;
            l = rd_l11;
            u = rd_unsupported;
         end else begin
            @(negedge sys_clk);
         end
      end
   endtask
endmodule

// File: dv/test_pmbus_status_telemetry_regs.sv
`timescale 1ns/1ps
module test_pmbus_status_telemetry_regs
   import pmbus_status_pkg::*;
;
   typedef struct {int ev; int ch; logic [PAGE_W-1:0] pg;
                   logic [7:0] cmd; logic [7:0] exp; logic al;} row_t;
   logic sys_clk, rst, vout_cmd_req, vin_insufficient, extra_byte;
   logic [NUM_CH-1:0] vout_ov_fault, vout_ov_warn, vout_uv_warn;
   logic [NUM_CH-1:0] vout_uv_fault, vout_ton_max_fault, discharge_fault;
   logic [NUM_CH-1:0] turn_on_try, fb1_shutdown, fb0_shutdown, chan_on_cmd;
   logic [NUM_CH-1:0] servo_reached, dac_connected, dac_saturated, adc_hires;
   logic [15:0] vout_cmd_value, vout_max_limit, adc_vin_word, adc_vout_word;
   logic [15:0] adc_temp_word, rd_data, d;
   logic vin_ov_fault, vin_ov_warn, vin_uv_warn, vin_uv_fault, l, u;
   logic temp_ot_fault, temp_ot_warn, temp_ut_warn, temp_ut_fault;
   logic bad_command, bad_data, extra_byte_pec_match, nvm_fault;
   logic malformed_txn, vinen_faulted_off, watchdog_fault, clear_faults;
   logic fault_bus_in_1_n, fault_bus_in_0_n, adc_vin_valid, adc_vout_valid;
   logic adc_temp_valid, rd_req, rd_valid, rd_l11, rd_unsupported;
   logic alert_out_n;
   logic [PAGE_W-1:0] adc_vout_ch, sel_page;
   logic [7:0] rd_cmd;
   int n_errors = 0;
   int n_tests = 0;
   row_t rows[] = '{
      '{0, 0, 3'h0, 8'h7A, 8'h80, 1'h0},
      '{1, 2, 3'h2, 8'h7A, 8'h40, 1'h0},
      '{2, 2, 3'h2, 8'h7A, 8'h20, 1'h0},
      '{3, 2, 3'h2, 8'h7A, 8'h10, 1'h0},
      '{4, 2, 3'h2, 8'h7A, 8'h04, 1'h0},
      '{0, 2, 3'h3, 8'h7A, 8'h00, 1'h0},
      '{5, 2, 3'h2, 8'h7A, 8'h08, 1'h0},
      '{6, 2, 3'h2, 8'h7A, 8'h00, 1'h1},
      '{7, 0, 3'h0, 8'h7C, 8'h80, 1'h0},
      '{8, 0, 3'h0, 8'h7C, 8'h40, 1'h0},
      '{9, 0, 3'h0, 8'h7C, 8'h20, 1'h0},
      '{10, 0, 3'h0, 8'h7C, 8'h10, 1'h0},
      '{11, 0, 3'h0, 8'h7D, 8'h80, 1'h0},
      '{12, 0, 3'h0, 8'h7D, 8'h40, 1'h0},
      '{13, 0, 3'h0, 8'h7D, 8'h20, 1'h0},
      '{14, 0, 3'h0, 8'h7D, 8'h10, 1'h0},
      '{15, 0, 3'h0, 8'h7E, 8'h80, 1'h0},
      '{16, 0, 3'h0, 8'h7E, 8'h40, 1'h0},
      '{17, 0, 3'h0, 8'h7E, 8'h20, 1'h0},
      '{18, 0, 3'h0, 8'h7E, 8'h00, 1'h1},
      '{19, 0, 3'h0, 8'h7E, 8'h10, 1'h0},
      '{20, 0, 3'h0, 8'h7E, 8'h02, 1'h0},
      '{21, 3, 3'h3, 8'h80, 8'h80, 1'h0},
      '{21, 3, 3'h4, 8'h80, 8'h00, 1'h0},
      '{22, 4, 3'h4, 8'h80, 8'h04, 1'h1},
      '{23, 0, 3'h5, 8'h80, 8'h01, 1'h0},
      '{24, 6, 3'h6, 8'h80, 8'h20, 1'h0},
      '{25, 6, 3'h6, 8'h80, 8'h40, 1'h0}};

   pmbus_status_telemetry_regs pmbus_status_telemetry_regs_i (.*);
   pmbus_host_model pmbus_host_model_i (.*);

   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rd(input logic [7:0] c, input logic [PAGE_W-1:0] p);
      bit ok;
      pmbus_host_model_i.read(c, p, d, l, u, ok);
      if (!ok) begin
         n_errors++;
         $display("BAD read expected answer seen none");
         report_and_stop();
      end
   endtask

   task automatic quiet();
      {vout_ov_fault, vout_ov_warn, vout_uv_warn, vout_uv_fault,
       vout_ton_max_fault, vout_cmd_req, vin_ov_fault, vin_ov_warn,
       vin_uv_warn, vin_uv_fault, temp_ot_fault, temp_ot_warn, temp_ut_warn,
       temp_ut_fault, bad_command, bad_data, extra_byte, nvm_fault,
       malformed_txn, discharge_fault, turn_on_try, fb1_shutdown,
       fb0_shutdown, chan_on_cmd, dac_saturated, watchdog_fault,
       clear_faults, adc_vin_valid, adc_vout_valid, adc_temp_valid} = '0;
   endtask

   task automatic apply(int ev, int ch);
      @(negedge sys_clk);
      pmbus_host_model_i.set_page(ch[PAGE_W-1:0]);
      vout_cmd_value = (ev == 5) ? 16'h1001 : 16'h1000;
      extra_byte_pec_match = (ev == 18);
      case (ev)
         0: vout_ov_fault[ch] = 1'h1;
         1: vout_ov_warn[ch] = 1'h1;
         2: vout_uv_warn[ch] = 1'h1;
         3: vout_uv_fault[ch] = 1'h1;
         4: vout_ton_max_fault[ch] = 1'h1;
         5, 6: vout_cmd_req = 1'h1;
         7: vin_ov_fault = 1'h1;
         8: vin_ov_warn = 1'h1;
         9: vin_uv_warn = 1'h1;
         10: vin_uv_fault = 1'h1;
         11: temp_ot_fault = 1'h1;
         12: temp_ot_warn = 1'h1;
         13: temp_ut_warn = 1'h1;
         14: temp_ut_fault = 1'h1;
         15: bad_command = 1'h1;
         16: bad_data = 1'h1;
         17, 18: extra_byte = 1'h1;
         19: nvm_fault = 1'h1;
         20: malformed_txn = 1'h1;
         21: discharge_fault[ch] = 1'h1;
         22: dac_saturated[ch] = 1'h1;
         23: watchdog_fault = 1'h1;
         24: fb0_shutdown[ch] = 1'h1;
         25: fb1_shutdown[ch] = 1'h1;
         26: turn_on_try[ch] = 1'h1;
         default: chan_on_cmd[ch] = 1'h1;
      endcase
      @(negedge sys_clk);
      quiet();
   endtask

   task automatic clear();
      @(negedge sys_clk);
      clear_faults = 1'h1;
      @(negedge sys_clk);
      quiet();
   endtask

   initial begin
      quiet();
      {vout_cmd_value, vin_insufficient, extra_byte_pec_match, servo_reached,
       dac_connected, vinen_faulted_off, adc_vin_word, adc_vout_word,
       adc_temp_word, adc_vout_ch, adc_hires} = '0;
      vout_max_limit = 16'h1000;
      fault_bus_in_1_n = 1'h1;
      fault_bus_in_0_n = 1'h1;
      rst = 1'h1;
      repeat (12) @(negedge sys_clk);
      chk("alert in reset", {15'h0, alert_out_n}, 16'h0001);
      chk("valid in reset", {15'h0, rd_valid}, 16'h0000);
      rst = 1'h0;
      // Let the pin filters settle before any event
      repeat (4) @(negedge sys_clk);
      foreach (rows[i]) begin
         apply(rows[i].ev, rows[i].ch);
         rd(rows[i].cmd, rows[i].pg);
         chk("status", d, {8'h00, rows[i].exp});
         chk("alert", {15'h0, alert_out_n}, {15'h0, rows[i].al});
         rd(rows[i].cmd, rows[i].pg);
         chk("status reread", d, {8'h00, rows[i].exp});
         clear();
         rd(rows[i].cmd, rows[i].pg);
         chk("status cleared", d, 16'h0000);
         chk("alert cleared", {15'h0, alert_out_n}, 16'h0001);
         $display("row %0d done", i);
      end
      fault_bus_in_1_n = 1'h0;
      repeat (5) @(negedge sys_clk);
      apply(26, 6);
      rd(8'h80, 3'h6);
      chk("turn on with pin low", d, 16'h0040);
      fault_bus_in_1_n = 1'h1;
      repeat (5) @(negedge sys_clk);
      clear();
      apply(22, 0);
      rd(8'h80, 3'h0);
      chk("sticky before on", d, 16'h0004);
      apply(27, 0);
      rd(8'h80, 3'h0);
      chk("sticky after on", d, 16'h0000);
      $display("pin and on tests done");
      servo_reached = 8'h02;
      dac_connected = 8'h02;
      vinen_faulted_off = 1'h1;
      vin_insufficient = 1'h1;
      rd(8'h80, 3'h1);
      chk("live vendor", d, 16'h001A);
      rd(8'h80, 3'h0);
      chk("shared vendor", d, 16'h0002);
      rd(8'h7C, 3'h0);
      chk("input off", d, 16'h0008);
      chk("live no alert", {15'h0, alert_out_n}, 16'h0001);
      {servo_reached, dac_connected, vinen_faulted_off, vin_insufficient} = '0;
      $display("live test done");
      @(negedge sys_clk);
      {adc_vin_word, adc_temp_word, adc_vout_word} = 48'h1234_ABCD_5678;
      {adc_vin_valid, adc_temp_valid, adc_vout_valid} = 3'h7;
      adc_vout_ch = 3'h1;
      adc_hires = 8'h02;
      apply(19, 0);
      rd(8'h88, 3'h0);
      chk("vin word", {d[14:0], l}, 16'h2469);
      rd(8'h8D, 3'h0);
      chk("temp word", {d[14:0], l}, 16'h579B);
      chk("temp word full", d, 16'hABCD);
      rd(8'h8B, 3'h1);
      chk("hires word", {d[14:0], l}, 16'hACF1);
      rd(8'h8B, 3'h0);
      chk("vout word", {d[14:0], l}, 16'h0000);
      rd(8'h98, 3'h0);
      chk("revision", d, {8'h00, REVISION_DEFAULT});
      rd(8'h01, 3'h0);
      chk("unknown code", {d[14:0], u}, 16'h0001);
      $display("word test done");
      @(negedge sys_clk);
      rst = 1'h1;
      repeat (2) @(negedge sys_clk);
      chk("alert mid reset", {15'h0, alert_out_n}, 16'h0001);
      rst = 1'h0;
      repeat (4) @(negedge sys_clk);
      rd(8'h7E, 3'h0);
      chk("status after reset", d, 16'h0000);
      $display("reset test done");
      report_and_stop();
   end
endmodule
